// ### hdl/phy_mii_consts.svh
// Constants for the transceiver MAC-side block: rates, times, register map.
// Assumes the system clock runs at CLK_HZ.
`ifndef PHY_MII_CONSTS_SVH
`define PHY_MII_CONSTS_SVH

`define CLK_HZ          50000000
`define TXC_HZ_FAST     25000000
`define TXC_HZ_SLOW     2500000
`define HALF_FAST       (`CLK_HZ / (2 * `TXC_HZ_FAST))
`define HALF_SLOW       (`CLK_HZ / (2 * `TXC_HZ_SLOW))
`define JABBER_MS       20
`define UNJAB_MS        250
`define JABBER_CYC      (`CLK_HZ / 1000 * `JABBER_MS)
`define UNJAB_CYC       (`CLK_HZ / 1000 * `UNJAB_MS)
`define HEARTBEAT_NS    1000
`define HEARTBEAT_CYC   ((`HEARTBEAT_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define PREAMBLE_ONES   6'h20
`define OP_READ         2'h2
`define OP_WRITE        2'h1
`define BCAST_ADDR      5'h00
`define REG_CTRL        5'h00
`define REG_STAT        5'h01
`define REG_ID_HI       5'h02
`define REG_ID_LO       5'h03
`define REG_ADV         5'h04
`define REG_LPA         5'h05
`define REG_ANEXP       5'h06
`define REG_INTR        5'h1B
`define REG_PHYCTL      5'h1F
`define CTRL_SPEED_BIT  13
`define CTRL_AN_BIT     12
`define CTRL_DUPLEX_BIT 8
`define PHYCTL_POL_BIT  9
`define ADV_ABIL_RESET  4'hF
`define IRQ_LINK_UP     0
`define IRQ_LINK_DOWN   1
`define IRQ_JABBER      2
`define IRQ_RX_ERR      3

`endif

// ### hdl/phy_mii_pkg.sv
// Types shared by the transceiver MAC-side block.
// Needs no other file.
package phy_mii_pkg;

  typedef enum logic [2:0] {
    MD_PRE   = 3'b000,
    MD_START = 3'b001,
    MD_OP    = 3'b010,
    MD_ADDR  = 3'b011,
    MD_TA    = 3'b100,
    MD_DATA  = 3'b101
  } mdio_state_type;

  // Code order is also the negotiation rank, best highest
  typedef enum logic [1:0] {
    MODE_10H  = 2'b00,
    MODE_10F  = 2'b01,
    MODE_100H = 2'b10,
    MODE_100F = 2'b11
  } link_mode_type;

endpackage

// ### hdl/phy_mii_side.sv
// MAC-facing side of a 10/100 transceiver: nibble data path, jabber and
// heartbeat, mode resolution, management frames and interrupt pin.
// Assumes phy_mii_consts.svh and phy_mii_pkg; mdc toggles during reset.
`timescale 1ns/1ps
`default_nettype none
`include "phy_mii_consts.svh"

module phy_mii_side
#(
  parameter logic [23:0] JABBER_CYCLES = 24'(`JABBER_CYC),
  parameter logic [23:0] UNJAB_CYCLES  = 24'(`UNJAB_CYC),
  parameter logic [15:0] ID_HI         = 16'h1234, // Arbitrary value
  parameter logic [15:0] ID_LO         = 16'h5678  // Arbitrary value
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [2:0] phy_address_strap,
  input  wire logic       negotiation_enable_strap,
  input  wire logic [2:0] config_strap,
  output logic            mii_selected,
  output logic            tx_clk,
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  output logic            rx_clk,
  output logic            rx_dv,
  output logic [3:0]      rxd,
  output logic            rx_er,
  output logic            crs,
  output logic            col,
  output logic            line_tx_en,
  output logic [3:0]      line_txd,
  input  wire logic       line_link,
  input  wire logic       line_carrier,
  input  wire logic [3:0] line_rxd,
  input  wire logic       line_sfd,
  input  wire logic       line_sym_err,
  input  wire logic       line_sig_100,
  input  wire logic       lp_negotiates,
  input  wire logic [3:0] lp_ability,
  output logic            interrupt_request_pin
);

  // Pin synchronisers, not reset so straps pass during reset
  logic [20:0] pin_m;
  logic [20:0] pin_s;
  always_ff @(posedge clk)
  begin
    pin_m <= {line_link, line_carrier, line_rxd, line_sfd, line_sym_err,
              line_sig_100, lp_negotiates, lp_ability, negotiation_enable_strap,
              config_strap, phy_address_strap};
    pin_s <= pin_m;
  end
  wire       s_link    = pin_s[20];
  wire       s_carrier = pin_s[19];
  wire [3:0] s_rxd     = pin_s[18:15];
  wire       s_sfd     = pin_s[14];
  wire       s_sym_err = pin_s[13];
  wire       s_sig_100 = pin_s[12];
  wire       s_lp_neg  = pin_s[11];
  wire [3:0] s_lp_ab   = pin_s[10:7];
  wire       s_an_pin  = pin_s[6];
  wire [2:0] s_cfg     = pin_s[5:3];
  wire [2:0] s_phy     = pin_s[2:0];

  // Straps captured while reset is held
  logic       an_strap;
  logic [2:0] phy_strap;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      an_strap     <= s_an_pin;
      phy_strap    <= s_phy;
      mii_selected <= (s_cfg == 3'b000);
    end
  end

  // Management-side settings, crossed as levels
  logic [16:0] ctl;
  logic [16:0] ctl_m;
  logic [16:0] ctl_s;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctl_m <= 17'h00000;
      ctl_s <= 17'h00000;
    end
    else
    begin
      ctl_m <= ctl;
      ctl_s <= ctl_m;
    end
  end
  wire       sw_written = ctl_s[16];
  wire       sw_an      = ctl_s[15];
  wire       f_100      = ctl_s[14];
  wire       f_full     = ctl_s[13];
  wire [3:0] adv_s      = ctl_s[12:9];
  wire [7:0] int_en_s   = ctl_s[8:1];
  wire       pol_s      = ctl_s[0];

  // Mode resolution
  phy_mii_pkg::link_mode_type mode;
  phy_mii_pkg::link_mode_type next_mode;
  logic       an_en;
  logic       link_up;
  logic       link_ok;
  logic       an_done;
  wire  [3:0] common = adv_s & s_lp_ab;
  wire        slow   = !mode[1];

  always_comb
  begin
    next_mode = mode;
    link_ok   = 1'b1;
    if (!an_en)
      next_mode = phy_mii_pkg::link_mode_type'({f_100, f_full});
    else if (s_lp_neg)
    begin
      link_ok = |common;
      if (common[3])
        next_mode = phy_mii_pkg::MODE_100F;
      else if (common[2])
        next_mode = phy_mii_pkg::MODE_100H;
      else if (common[1])
        next_mode = phy_mii_pkg::MODE_10F;
      else if (common[0])
        next_mode = phy_mii_pkg::MODE_10H;
    end
    else if (s_sig_100)
      next_mode = phy_mii_pkg::MODE_100H;
    else
      next_mode = phy_mii_pkg::MODE_10H;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode    <= phy_mii_pkg::MODE_100H;
      an_en   <= 1'b0;
      link_up <= 1'b0;
      an_done <= 1'b0;
    end
    else
    begin
      mode    <= next_mode;
      an_en   <= sw_written ? sw_an : an_strap;
      link_up <= s_link && link_ok;
      an_done <= an_en && s_link && link_ok;
    end
  end

  // Reference-derived clocks; recovered timing is folded onto the same divider
  logic [3:0] div_cnt;
  wire  [3:0] div_half = mode[1] ? 4'(`HALF_FAST) : 4'(`HALF_SLOW);
  wire        div_end  = (div_cnt >= div_half - 4'h1);
  wire        tx_rise  = div_end && !tx_clk;
  wire        tx_fall  = div_end && tx_clk;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_cnt <= 4'h0;
      tx_clk  <= 1'b0;
      rx_clk  <= 1'b0;
    end
    else if (div_end)
    begin
      div_cnt <= 4'h0;
      tx_clk  <= !tx_clk;
      rx_clk  <= !tx_clk;
    end
    else
      div_cnt <= div_cnt + 4'h1;
  end

  // Transmit sampling at each transmit clock rise
  logic tx_en_q;
  logic jabber;
  wire  txen_fall = tx_rise && tx_en_q && !tx_en;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_en_q    <= 1'b0;
      line_tx_en <= 1'b0;
      line_txd   <= 4'h0;
    end
    else if (tx_rise)
    begin
      tx_en_q    <= tx_en;
      line_tx_en <= tx_en && mii_selected && !jabber;
      line_txd   <= tx_en ? txd : 4'h0;
    end
  end

  // Jabber lockout, 10M only; one counter serves both phases
  logic [23:0] jab_cnt;
  always_ff @(posedge clk)
  begin
    if (sys_rst || !slow)
    begin
      jab_cnt <= 24'h000000;
      jabber  <= 1'b0;
    end
    else if (!jabber)
    begin
      if (!tx_en_q)
        jab_cnt <= 24'h000000;
      else if (jab_cnt > JABBER_CYCLES)
      begin
        jabber  <= 1'b1;
        jab_cnt <= 24'h000000;
      end
      else
        jab_cnt <= jab_cnt + 24'h000001;
    end
    else
    begin
      if (tx_en_q)
        jab_cnt <= 24'h000000;
      else if (jab_cnt > UNJAB_CYCLES)
      begin
        jabber  <= 1'b0;
        jab_cnt <= 24'h000000;
      end
      else
        jab_cnt <= jab_cnt + 24'h000001;
    end
  end

  // Heartbeat after each frame at 10M, except while jabber is set
  logic [5:0] hb_cnt;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      hb_cnt <= 6'h00;
    else if (txen_fall && slow && !jabber)
      hb_cnt <= 6'(`HEARTBEAT_CYC);
    else if (hb_cnt != 6'h00)
      hb_cnt <= hb_cnt - 6'h01;
  end

  // Receive path, updated as the receive clock falls
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_dv <= 1'b0;
      rxd   <= 4'h0;
      rx_er <= 1'b0;
    end
    else if (tx_fall)
    begin
      rx_dv <= mii_selected && s_carrier && (mode[1] || rx_dv || s_sfd);
      rxd   <= s_carrier ? s_rxd : 4'h0;
      rx_er <= s_carrier && s_sym_err;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      crs <= 1'b0;
      col <= 1'b0;
    end
    else
    begin
      crs <= s_carrier || tx_en_q;
      col <= (!mode[0] && tx_en_q && s_carrier) || jabber || (hb_cnt != 6'h00);
    end
  end

  // Interrupt status; a set in the clearing cycle survives
  logic [7:0] irq_stat;
  logic [7:0] events;
  logic [7:0] clr_snap;
  logic       clr_tgl;
  logic       clr_m;
  logic       clr_s;
  logic       clr_d;
  logic       link_prev;
  logic       jab_prev;
  wire        clr_evt = clr_s ^ clr_d;

  always_comb
  begin
    events                 = 8'h00;
    events[`IRQ_LINK_UP]   = link_up && !link_prev;
    events[`IRQ_LINK_DOWN] = !link_up && link_prev;
    events[`IRQ_JABBER]    = jabber && !jab_prev;
    events[`IRQ_RX_ERR]    = tx_fall && s_carrier && s_sym_err;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clr_m     <= 1'b0;
      clr_s     <= 1'b0;
      clr_d     <= 1'b0;
      link_prev <= 1'b0;
      jab_prev  <= 1'b0;
      irq_stat  <= 8'h00;
      interrupt_request_pin <= 1'b1;
    end
    else
    begin
      clr_m     <= clr_tgl;
      clr_s     <= clr_m;
      clr_d     <= clr_s;
      link_prev <= link_up;
      jab_prev  <= jabber;
      // Snapshot is held steady by the management side between reads
      irq_stat  <= (irq_stat & ~(clr_evt ? clr_snap : 8'h00)) | events;
      interrupt_request_pin <= (|(irq_stat & int_en_s)) ? pol_s : !pol_s;
    end
  end

  // Management clock domain
  logic        rst_m_m;
  logic        rst_m;
  logic [20:0] st_m;
  logic [20:0] st_s;
  always_ff @(posedge mdc)
  begin
    rst_m_m <= sys_rst;
    rst_m   <= rst_m_m;
    st_m    <= {phy_strap, an_en, s_lp_neg, s_lp_ab, link_up, an_done, mode, irq_stat};
    st_s    <= st_m;
  end
  wire [2:0] m_phy    = st_s[20:18];
  wire       m_an     = st_s[17];
  wire       m_lp_neg = st_s[16];
  wire [3:0] m_lp_ab  = st_s[15:12];
  wire       m_link   = st_s[11];
  wire       m_done   = st_s[10];
  wire [7:0] m_irq    = st_s[7:0];

  phy_mii_pkg::mdio_state_type md_state;
  logic [5:0]  cnt;
  logic [15:0] sh;
  logic [1:0]  op;
  logic [4:0]  reg_a;
  logic [15:0] rd_val;
  logic        written;
  logic        an_sw;
  logic        force_100;
  logic        force_full;
  logic [3:0]  adv;
  logic [7:0]  int_en;
  logic        pol;
  wire  [4:0]  phy_now  = sh[8:4];
  wire  [4:0]  reg_now  = {sh[3:0], mdio_in};
  wire         addr_hit = (phy_now == `BCAST_ADDR) || (phy_now == {2'b00, m_phy});
  wire         is_read  = (op == `OP_READ);
  wire         wr_now   = (md_state == phy_mii_pkg::MD_DATA) && (cnt == 6'h0F) && (op == `OP_WRITE);
  wire  [15:0] wr_data  = {sh[14:0], mdio_in};
  assign ctl = {written, an_sw, force_100, force_full, adv, int_en, pol};

  always_comb
  begin
    rd_val = 16'h0000;
    case (reg_now)
      `REG_CTRL:   rd_val = {2'b00, force_100, m_an, 3'b000, force_full, 8'h00};
      `REG_STAT:   rd_val = {1'b0, 4'hF, 5'h00, m_done, 1'b0, 1'b1, m_link, 2'b01};
      `REG_ID_HI:  rd_val = ID_HI;
      `REG_ID_LO:  rd_val = ID_LO;
      `REG_ADV:    rd_val = {7'h00, adv, 5'h01};
      `REG_LPA:    rd_val = {7'h00, m_lp_ab, 5'h01};
      `REG_ANEXP:  rd_val = {15'h0000, m_lp_neg};
      `REG_INTR:   rd_val = {int_en, m_irq};
      `REG_PHYCTL: rd_val = {6'h00, pol, 9'h000};
      default:     rd_val = 16'h0000;
    endcase
  end

  // Frame parser; every bit is sampled on the mdc rise
  always_ff @(posedge mdc)
  begin
    if (rst_m)
    begin
      md_state <= phy_mii_pkg::MD_PRE;
      cnt      <= 6'h00;
      sh       <= 16'h0000;
      op       <= 2'b00;
      reg_a    <= 5'h00;
      mdio_oe  <= 1'b0;
      mdio_out <= 1'b0;
      clr_tgl  <= 1'b0;
      clr_snap <= 8'h00;
    end
    else
    begin
      unique case (md_state)
        phy_mii_pkg::MD_PRE:
        begin
          mdio_oe  <= 1'b0;
          mdio_out <= 1'b0;
          if (mdio_in)
            cnt <= (cnt == `PREAMBLE_ONES) ? cnt : cnt + 6'h01;
          else
          begin
            cnt <= 6'h00;
            if (cnt == `PREAMBLE_ONES)
              md_state <= phy_mii_pkg::MD_START;
          end
        end
        phy_mii_pkg::MD_START:
        begin
          cnt      <= 6'h00;
          md_state <= mdio_in ? phy_mii_pkg::MD_OP : phy_mii_pkg::MD_PRE;
        end
        phy_mii_pkg::MD_OP:
        begin
          op  <= {op[0], mdio_in};
          cnt <= cnt + 6'h01;
          if (cnt == 6'h01)
          begin
            cnt      <= 6'h00;
            md_state <= phy_mii_pkg::MD_ADDR;
          end
        end
        phy_mii_pkg::MD_ADDR:
        begin
          sh  <= {sh[14:0], mdio_in};
          cnt <= cnt + 6'h01;
          if (cnt == 6'h09)
          begin
            cnt   <= 6'h00;
            reg_a <= reg_now;
            if (addr_hit && (is_read || op == `OP_WRITE))
            begin
              md_state <= phy_mii_pkg::MD_TA;
              if (is_read)
                sh <= rd_val;
              if (is_read && reg_now == `REG_INTR)
              begin
                clr_snap <= m_irq;
                clr_tgl  <= !clr_tgl;
              end
            end
            else
              md_state <= phy_mii_pkg::MD_PRE;
          end
        end
        phy_mii_pkg::MD_TA:
        begin
          cnt <= cnt + 6'h01;
          if (is_read && cnt == 6'h00)
          begin
            mdio_oe  <= 1'b1;
            mdio_out <= 1'b0;
          end
          else if (is_read)
          begin
            mdio_out <= sh[15];
            sh       <= {sh[14:0], 1'b0};
          end
          if (cnt == 6'h01)
          begin
            cnt      <= 6'h00;
            md_state <= phy_mii_pkg::MD_DATA;
          end
        end
        phy_mii_pkg::MD_DATA:
        begin
          cnt <= cnt + 6'h01;
          sh  <= {sh[14:0], mdio_in};
          if (is_read)
            mdio_out <= sh[15];
          if (cnt == 6'h0F)
          begin
            cnt      <= 6'h00;
            mdio_oe  <= 1'b0;
            md_state <= phy_mii_pkg::MD_PRE;
          end
        end
        default:
          md_state <= phy_mii_pkg::MD_PRE;
      endcase
    end
  end

  // Writable register fields
  always_ff @(posedge mdc)
  begin
    if (rst_m)
    begin
      written    <= 1'b0;
      an_sw      <= 1'b0;
      force_100  <= 1'b1;
      force_full <= 1'b0;
      adv        <= `ADV_ABIL_RESET;
      int_en     <= 8'h00;
      pol        <= 1'b0;
    end
    else if (wr_now)
    begin
      case (reg_a)
        `REG_CTRL:
        begin
          written    <= 1'b1;
          an_sw      <= wr_data[`CTRL_AN_BIT];
          force_100  <= wr_data[`CTRL_SPEED_BIT];
          force_full <= wr_data[`CTRL_DUPLEX_BIT];
        end
        `REG_ADV:    adv    <= wr_data[8:5];
        `REG_INTR:   int_en <= wr_data[15:8];
        `REG_PHYCTL: pol    <= wr_data[`PHYCTL_POL_BIT];
        default:     ;
      endcase
    end
  end

  AST_JABBER_COL: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(jabber) |=> col)
    else $error("collision not raised on jabber");
  AST_JABBER_CAUSE: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(jabber) |-> $past(tx_en_q) && $past(slow))
    else $error("jabber without long transmit at 10M");
  AST_UNJAB: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(jabber) && slow |-> !$past(tx_en_q))
    else $error("jabber released while transmitting");
  AST_HEARTBEAT: assert property (@(posedge clk) disable iff (sys_rst)
    txen_fall && slow && !jabber |=> ##1 col [*2])
    else $error("no heartbeat after frame");
  AST_AN_BEST: assert property (@(posedge clk) disable iff (sys_rst)
    an_en && s_lp_neg && common[3] |=> mode == phy_mii_pkg::MODE_100F)
    else $error("best common mode not chosen");
  AST_PARALLEL: assert property (@(posedge clk) disable iff (sys_rst)
    an_en && !s_lp_neg && s_sig_100 |=> mode == phy_mii_pkg::MODE_100H)
    else $error("parallel detect failed");
  AST_TX_IGNORE: assert property (@(posedge clk) disable iff (sys_rst)
    tx_rise && !tx_en |=> !line_tx_en && line_txd == 4'h0)
    else $error("data taken without enable");
  AST_RXDV_FAST: assert property (@(posedge clk) disable iff (sys_rst)
    tx_fall && mii_selected && s_carrier && mode[1] |=> rx_dv)
    else $error("receive valid missing at 100M");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
    (|(irq_stat & int_en_s)) |=> interrupt_request_pin == $past(pol_s))
    else $error("interrupt pin not asserted");
  AST_TA_ZERO: assert property (@(posedge mdc) disable iff (rst_m)
    md_state == phy_mii_pkg::MD_TA && cnt == 6'h00 && is_read |=> mdio_oe && !mdio_out)
    else $error("turnaround zero not driven");
  AST_IDLE_RELEASED: assert property (@(posedge mdc) disable iff (rst_m)
    md_state == phy_mii_pkg::MD_PRE |-> !mdio_oe)
    else $error("data line driven while idle");

endmodule

`default_nettype wire

// ### verif/mdio_ctrl_model.sv
// Management controller model: runs mdc only when a tick or frame is called, drives the data line.
// Assumes the data line is resolved outside, with a pull-up when nobody drives.
`timescale 1ns/1ps
`default_nettype none
module mdio_ctrl_model
(
  output logic     mdc,
  output logic     drv_oe,
  output logic     drv_val,
  input  wire logic line
);
  initial
  begin
    mdc = 1'b0;
    drv_oe = 1'b0;
    drv_val = 1'b0;
  end

  // Changes land just after mdc falls, well clear of the sampling rise
  task automatic tick(input logic b);
    begin
      drv_val = b;
      #3 mdc = 1'b1;
      #3 mdc = 1'b0;
    end
  endtask

  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rdat, output logic ta0);
    logic [45:0] hdr;
    logic [16:0] cap;
    begin
      cap = '1;
      hdr = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, rg};
      drv_oe = 1'b1;
      for (int i = 45; i >= 0; i--)
        tick(hdr[i]);
      if (rd)
      begin
        drv_oe = 1'b0;
        tick(1'b0);
        for (int i = 16; i >= 0; i--)
        begin
          #3 cap[i] = line;
          mdc = 1'b1;
          #3 mdc = 1'b0;
        end
      end
      else
      begin
        tick(1'b1);
        tick(1'b0);
        for (int i = 15; i >= 0; i--)
          tick(wd[i]);
      end
      drv_oe = 1'b0;
      {ta0, rdat} = cap;
    end
  endtask
endmodule
`default_nettype wire

// ### verif/phy_mii_side_tb.sv
// Bench for the transceiver MAC side: management, modes, data path, jabber.
// Assumes the controller model and a pulled-up management data line.
`timescale 1ns/1ps
`default_nettype none
module phy_mii_side_tb;
  logic        clk = 1'b0, sys_rst = 1'b1, tx_en = 1'b0, neg_strap = 1'b1;
  logic        line_carrier = 1'b0, line_sym_err = 1'b0, line_sig_100 = 1'b0;
  logic        line_link = 1'b1, line_sfd = 1'b0;
  logic [2:0]  phy_pin = 3'h5;
  logic        lp_negotiates = 1'b1, ta;
  logic [3:0]  txd = 4'h0, line_rxd = 4'h0, lp_ability = 4'h8, rxd, line_txd;
  logic        mdc, drv_oe, drv_val, mdio_out, mdio_oe, mii_sel, tx_clk, rx_clk;
  logic        rx_dv, rx_er, crs, col, line_tx_en, pin;
  logic [15:0] rd, r;
  int          n_fail = 0, checked = 0;
  wire logic   mdio_line = mdio_oe ? mdio_out : (drv_oe ? drv_val : 1'b1);

  always #10 clk = ~clk;

  mdio_ctrl_model m (.mdc(mdc), .drv_oe(drv_oe), .drv_val(drv_val), .line(mdio_line));

  phy_mii_side #(.JABBER_CYCLES(24'd200), .UNJAB_CYCLES(24'd500)) dut (
    .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_address_strap(phy_pin), .negotiation_enable_strap(neg_strap),
    .config_strap(3'h0), .mii_selected(mii_sel), .tx_clk(tx_clk), .tx_en(tx_en),
    .txd(txd), .rx_clk(rx_clk), .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er), .crs(crs),
    .col(col), .line_tx_en(line_tx_en), .line_txd(line_txd), .line_link(line_link),
    .line_carrier(line_carrier), .line_rxd(line_rxd), .line_sfd(line_sfd),
    .line_sym_err(line_sym_err), .line_sig_100(line_sig_100),
    .lp_negotiates(lp_negotiates), .lp_ability(lp_ability), .interrupt_request_pin(pin));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      checked++;
      if (got !== exp)
      begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task automatic summarize;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic mg(input logic rw, input logic [4:0] a, input logic [4:0] g,
                    input logic [15:0] w);
    m.frame(rw, a, g, w, rd, ta);
  endtask

  // Fixed window of 200 clk holds exactly 100 rises at 100M, 10 at 10M
  task automatic rises(input logic [15:0] exp);
    logic [1:0]  prev;
    logic [15:0] q;
    begin
      cyc(30);
      r = 0;
      q = 0;
      prev = {rx_clk, tx_clk};
      repeat (200)
      begin
        @(negedge clk);
        r += 16'(tx_clk & ~prev[0]);
        q += 16'(rx_clk & ~prev[1]);
        prev = {rx_clk, tx_clk};
      end
      check("tx_clk rises", exp, r);
      check("rx_clk rises", exp, q);
    end
  endtask

  task automatic err_burst;
    begin
      line_carrier = 1'b1;
      line_rxd = 4'h6;
      line_sym_err = 1'b1;
      cyc(8);
      check("rx_dv", 1, rx_dv);
      check("rxd", 6, rxd);
      check("rx_er", 1, rx_er);
      line_carrier = 1'b0;
      line_sym_err = 1'b0;
      cyc(8);
      check("rx_dv idle", 0, rx_dv);
    end
  endtask

  task automatic t_regs;
    begin
      mg(1, 5'h05, 5'h04, 0);
      check("adv", 16'h01E1, rd);
      check("ta", 0, ta);
      mg(1, 5'h05, 5'h10, 0);
      check("unmapped", 0, rd);
      mg(1, 5'h02, 5'h04, 0);
      check("other phy", 16'hFFFF, rd);
      mg(1, 5'h0D, 5'h04, 0);
      check("upper addr bits", 16'hFFFF, rd);
      check("mii selected", 1, mii_sel);
      mg(0, 5'h00, 5'h1B, 16'h0800);
      mg(1, 5'h00, 5'h1B, 0);
      check("bcast enables", 16'h0800, rd & 16'hFF00);
      $display("regs done");
    end
  endtask

  task automatic t_intr;
    begin
      mg(0, 5'h05, 5'h1B, 0);
      mg(1, 5'h05, 5'h1B, 0);
      err_burst();
      check("pin masked", 1, pin);
      mg(1, 5'h05, 5'h1B, 0);
      check("status set", 16'h0008, rd & 16'h0008);
      mg(1, 5'h05, 5'h1B, 0);
      check("status cleared", 0, rd & 16'h0008);
      mg(0, 5'h05, 5'h1B, 16'h0800);
      err_burst();
      check("pin low active", 0, pin);
      mg(0, 5'h05, 5'h1F, 16'h0200);
      cyc(6);
      check("pin high active", 1, pin);
      mg(1, 5'h05, 5'h1B, 0);
      cyc(6);
      check("pin after read", 0, pin);
      $display("intr done");
    end
  endtask

  task automatic t_mode;
    logic [3:0] ab [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    begin
      for (int i = 0; i < 4; i++)
      begin
        lp_ability = ab[i];
        rises(i < 2 ? 16'd100 : 16'd10);
      end
      lp_negotiates = 1'b0;
      line_sig_100 = 1'b1;
      rises(16'd100);
      line_sig_100 = 1'b0;
      rises(16'd10);
      lp_negotiates = 1'b1;
      lp_ability = 4'h8;
      mg(0, 5'h05, 5'h00, 16'h0000);
      rises(16'd10);
      mg(0, 5'h05, 5'h00, 16'h1000);
      rises(16'd100);
      $display("mode done");
    end
  endtask

  task automatic t_tx;
    begin
      tx_en = 1'b1;
      txd = 4'h5;
      cyc(3);
      check("line_tx_en", 1, line_tx_en);
      check("line_txd", 5, line_txd);
      tx_en = 1'b0;
      txd = 4'hA;
      cyc(3);
      check("line_tx_en off", 0, line_tx_en);
      check("line_txd off", 0, line_txd);
      $display("tx done");
    end
  endtask

  task automatic t_jab;
    int n;
    begin
      lp_ability = 4'h1;
      cyc(40);
      tx_en = 1'b1;
      cyc(40);
      tx_en = 1'b0;
      n = 0;
      while (col !== 1'b1 && n < 60)
      begin
        cyc(1);
        n++;
      end
      check("heartbeat start", 1, col);
      n = 0;
      while (col === 1'b1 && n < 100)
      begin
        cyc(1);
        n++;
      end
      check("heartbeat len", 16'd50, 16'(n));
      tx_en = 1'b1;
      cyc(260);
      check("jabber col", 1, col);
      check("jabber tx off", 0, line_tx_en);
      tx_en = 1'b0;
      cyc(300);
      check("still locked", 1, col);
      cyc(300);
      check("unjabbed", 0, col);
      $display("jabber done");
    end
  endtask

  // Runs in 10M half duplex, left behind by the jabber scenario
  task automatic t_rx10;
    begin
      line_carrier = 1'b1;
      line_rxd = 4'h5;
      cyc(45);
      check("rx_dv before sfd", 0, rx_dv);
      line_sfd = 1'b1;
      line_rxd = 4'hD;
      cyc(25);
      line_sfd = 1'b0;
      check("rx_dv at sfd", 1, rx_dv);
      tx_en = 1'b1;
      cyc(30);
      check("rx_dv held", 1, rx_dv);
      check("col half duplex", 1, col);
      check("crs", 1, crs);
      tx_en = 1'b0;
      line_carrier = 1'b0;
      cyc(100);
      check("col idle", 0, col);
      $display("rx10 done");
    end
  endtask

  initial
  begin
    fork
      cyc(8);
      repeat (20) m.tick(1'b1);
    join
    sys_rst = 1'b0;
    // Management reset leaves through two mdc flops; mdc must run to free it
    repeat (4) m.tick(1'b1);
    cyc(20);
    t_regs();
    t_intr();
    t_mode();
    t_tx();
    t_jab();
    t_rx10();
    summarize();
  end
endmodule
`default_nettype wire
